// file: design/mmx_exec.sv
// move, multiply and negate execution datapath with an axi4-lite register slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mmx_cfg.svh"

// Summary of operation
// - load-literal puts the 8-bit literal into the accumulator, no flags, one cycle.
// - store-accumulator copies the accumulator into the addressed file register, no flags.
// - file address operand is 8 bits, reaching any byte of a 256-byte bank.
// - access bit 0 selects the access bank; 1 uses bank select register.
// - extended set, access bit 0, address up to 95: indexed literal offset addressing.
// - multiply-file forms unsigned accumulator times file into product pair, sources kept.
// - both multiplies leave every status flag untouched.
// - negate replaces the file register with inverted value plus one.
// - negate updates negative, overflow, carry, digit-carry and zero flags.
// - load-bank-select writes the literal but the upper four bits stay zero.
module mmx_exec (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // data memory port
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata
);

  // bus handshake state
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic wr_fire;
  logic wr_known;
  // core state
  mmx_pkg::mmx_phase_e phase_reg, phase_next;
  mmx_pkg::mmx_op_e op_reg, op_next;
  logic [15:0] instr_reg, instr_next;
  logic [7:0] acc_reg, acc_next, prod_hi_reg, prod_hi_next, prod_lo_reg, prod_lo_next;
  logic [7:0] opnd_reg, opnd_next, result_reg, result_next;
  logic [3:0] bank_select_register, bank_select_next;
  logic [4:0] flags_reg, flags_next;
  logic [11:0] index_reg, index_next;
  logic ext_en_reg, ext_en_next;
  logic [11:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic mem_we_reg, mem_we_next;
  // datapath terms
  logic [15:0] product;
  logic [7:0] neg_sum;
  logic [11:0] file_addr;
  logic [7:0] fa;
  logic acc_bit;

  // writes wait while an instruction is running so bus and core never fight over a register
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg && (phase_reg == mmx_pkg::ST_IDLE);

  always_comb begin
    wr_known = (awaddr_reg == `MMX_OFF_CTRL) || (awaddr_reg == `MMX_OFF_INSTR) || (awaddr_reg == `MMX_OFF_ACC) ||
      (awaddr_reg == `MMX_OFF_BANK) || (awaddr_reg == `MMX_OFF_INDEX);
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    // an empty read side offers arready again, which also covers the first cycle after reset
    arready_next = arready_reg || !rvalid_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next = {s_axi_awaddr[11:2], 2'h0};
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_have_next = 1'b1;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_known ? `MMX_RESP_OKAY : `MMX_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = `MMX_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'h0})
        `MMX_OFF_CTRL: rdata_next = {31'h0, ext_en_reg};
        `MMX_OFF_INSTR: rdata_next = {16'h0, instr_reg};
        `MMX_OFF_ACC: rdata_next = {24'h0, acc_reg};
        `MMX_OFF_BANK: rdata_next = {28'h0, bank_select_register};
        `MMX_OFF_PROD: rdata_next = {16'h0, prod_hi_reg, prod_lo_reg};
        `MMX_OFF_STATUS: rdata_next = {27'h0, flags_reg};
        `MMX_OFF_INDEX: rdata_next = {20'h0, index_reg};
        `MMX_OFF_STATE: rdata_next = {31'h0, phase_reg != mmx_pkg::ST_IDLE};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `MMX_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `MMX_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `MMX_RESP_OKAY;
      rdata_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awaddr_reg <= 12'h000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awaddr_reg <= awaddr_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
    end
  end

  // file address: 8-bit operand widened by bank, access bank or index base
  always_comb begin
    fa = instr_reg[7:0];
    acc_bit = instr_reg[8];
    if (acc_bit) begin
      file_addr = {bank_select_register, fa};
    end else if (ext_en_reg && fa <= `MMX_IDX_LIMIT) begin
      file_addr = index_reg + {4'h0, fa};
    end else if (fa < `MMX_ACCESS_SPLIT) begin
      file_addr = {4'h0, fa};
    end else begin
      file_addr = {`MMX_ACCESS_HIGH, fa};
    end
  end

  assign product = {8'h00, acc_reg} * {8'h00, opnd_reg};
  assign neg_sum = ~opnd_reg + 8'h01;

  always_comb begin
    phase_next = phase_reg;
    op_next = op_reg;
    instr_next = instr_reg;
    acc_next = acc_reg;
    prod_hi_next = prod_hi_reg;
    prod_lo_next = prod_lo_reg;
    opnd_next = opnd_reg;
    result_next = result_reg;
    bank_select_next = bank_select_register;
    flags_next = flags_reg;
    index_next = index_reg;
    ext_en_next = ext_en_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_we_next = 1'b0;
    if (wr_fire && wstrb_reg[0]) begin
      case (awaddr_reg)
        `MMX_OFF_CTRL: ext_en_next = wdata_reg[`MMX_CTRL_EXT_BIT];
        `MMX_OFF_ACC: acc_next = wdata_reg[7:0];
        `MMX_OFF_BANK: bank_select_next = wdata_reg[3:0];
        `MMX_OFF_INDEX: index_next[7:0] = wdata_reg[7:0];
        default: ;
      endcase
    end
    if (wr_fire && wstrb_reg[1] && awaddr_reg == `MMX_OFF_INDEX) begin
      index_next[11:8] = wdata_reg[11:8];
    end
    // an instruction word needs both low lanes, half a word would run garbage
    if (wr_fire && awaddr_reg == `MMX_OFF_INSTR && wstrb_reg[1:0] == 2'h3) begin
      instr_next = wdata_reg[15:0];
      phase_next = mmx_pkg::ST_Q1;
    end
    case (phase_reg)
      mmx_pkg::ST_IDLE: ;
      mmx_pkg::ST_Q1: begin
        // decode
        if (instr_reg[15:8] == `MMX_OP_MOVE_LIT) op_next = mmx_pkg::OP_MOVE_LIT;
        else if (instr_reg[15:8] == `MMX_OP_MUL_LIT) op_next = mmx_pkg::OP_MUL_LIT;
        else if (instr_reg[15:8] == `MMX_OP_BANK_LIT) op_next = mmx_pkg::OP_BANK_LIT;
        else if (instr_reg[15:9] == `MMX_OP_MUL_FILE) op_next = mmx_pkg::OP_MUL_FILE;
        else if (instr_reg[15:9] == `MMX_OP_NEG_FILE) op_next = mmx_pkg::OP_NEG_FILE;
        else if (instr_reg[15:9] == `MMX_OP_STORE_FILE) op_next = mmx_pkg::OP_STORE_FILE;
        else op_next = mmx_pkg::OP_NONE;
        mem_addr_next = file_addr;
        phase_next = mmx_pkg::ST_Q2;
      end
      mmx_pkg::ST_Q2: begin
        // read literal or file operand
        if (op_reg == mmx_pkg::OP_MUL_FILE || op_reg == mmx_pkg::OP_NEG_FILE) opnd_next = mem_rdata;
        else opnd_next = instr_reg[7:0];
        phase_next = mmx_pkg::ST_Q3;
      end
      mmx_pkg::ST_Q3: begin
        // process
        result_next = (op_reg == mmx_pkg::OP_NEG_FILE) ? neg_sum : acc_reg;
        phase_next = mmx_pkg::ST_Q4;
      end
      mmx_pkg::ST_Q4: begin
        // write destination
        case (op_reg)
          mmx_pkg::OP_MOVE_LIT: acc_next = opnd_reg;
          mmx_pkg::OP_BANK_LIT: bank_select_next = opnd_reg[3:0];
          mmx_pkg::OP_MUL_LIT, mmx_pkg::OP_MUL_FILE: begin
            // flags untouched, sources untouched
            prod_hi_next = product[15:8];
            prod_lo_next = product[7:0];
          end
          mmx_pkg::OP_STORE_FILE: begin
            mem_wdata_next = result_reg;
            mem_we_next = 1'b1;
          end
          mmx_pkg::OP_NEG_FILE: begin
            mem_wdata_next = result_reg;
            mem_we_next = 1'b1;
            flags_next[`MMX_FLAG_N] = result_reg[7];
            flags_next[`MMX_FLAG_Z] = (result_reg == 8'h00);
            flags_next[`MMX_FLAG_OV] = (opnd_reg == 8'h80);
            flags_next[`MMX_FLAG_C] = (opnd_reg == 8'h00);
            flags_next[`MMX_FLAG_DC] = (opnd_reg[3:0] == 4'h0);
          end
          default: ;
        endcase
        phase_next = mmx_pkg::ST_IDLE;
      end
      default: phase_next = mmx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= mmx_pkg::ST_IDLE;
      op_reg <= mmx_pkg::OP_NONE;
      instr_reg <= 16'h0000;
      acc_reg <= `MMX_RST_ACC;
      prod_hi_reg <= 8'h00;
      prod_lo_reg <= 8'h00;
      opnd_reg <= 8'h00;
      result_reg <= 8'h00;
      bank_select_register <= `MMX_RST_BANK;
      flags_reg <= `MMX_RST_FLAGS;
      index_reg <= `MMX_RST_INDEX;
      ext_en_reg <= 1'b0;
      mem_addr_reg <= 12'h000;
      mem_wdata_reg <= 8'h00;
      mem_we_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      instr_reg <= instr_next;
      acc_reg <= acc_next;
      prod_hi_reg <= prod_hi_next;
      prod_lo_reg <= prod_lo_next;
      opnd_reg <= opnd_next;
      result_reg <= result_next;
      bank_select_register <= bank_select_next;
      flags_reg <= flags_next;
      index_reg <= index_next;
      ext_en_reg <= ext_en_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_we_reg <= mem_we_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_we = mem_we_reg;

endmodule : mmx_exec
`default_nettype wire

// file: design/mmx_cfg.svh
// register offsets, field positions, reset values and opcode codes of the exec block
`ifndef MMX_CFG_SVH
`define MMX_CFG_SVH

`define MMX_OFF_CTRL 12'h000
`define MMX_OFF_INSTR 12'h004
`define MMX_OFF_ACC 12'h008
`define MMX_OFF_BANK 12'h00C
`define MMX_OFF_PROD 12'h010
`define MMX_OFF_STATUS 12'h014
`define MMX_OFF_INDEX 12'h018
`define MMX_OFF_STATE 12'h01C

`define MMX_CTRL_EXT_BIT 0
`define MMX_FLAG_C 0
`define MMX_FLAG_DC 1
`define MMX_FLAG_Z 2
`define MMX_FLAG_OV 3
`define MMX_FLAG_N 4

`define MMX_RST_ACC 8'h00
`define MMX_RST_BANK 4'h0
`define MMX_RST_FLAGS 5'h00
`define MMX_RST_INDEX 12'h000

`define MMX_OP_MOVE_LIT 8'h0E
`define MMX_OP_MUL_LIT 8'h0D
`define MMX_OP_BANK_LIT 8'h01
`define MMX_OP_MUL_FILE 7'h01
`define MMX_OP_NEG_FILE 7'h36
`define MMX_OP_STORE_FILE 7'h37

`define MMX_IDX_LIMIT 8'h5F
`define MMX_ACCESS_SPLIT 8'h60
`define MMX_ACCESS_HIGH 4'hF

`define MMX_RESP_OKAY 2'h0
`define MMX_RESP_SLVERR 2'h2

`endif

// file: design/mmx_pkg.sv
// types shared by the exec block
package mmx_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_Q1 = 5'h02,
    ST_Q2 = 5'h04,
    ST_Q3 = 5'h08,
    ST_Q4 = 5'h10
  } mmx_phase_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MOVE_LIT = 3'h1,
    OP_STORE_FILE = 3'h2,
    OP_MUL_LIT = 3'h3,
    OP_MUL_FILE = 3'h4,
    OP_NEG_FILE = 3'h5,
    OP_BANK_LIT = 3'h6
  } mmx_op_e;

endpackage : mmx_pkg

// file: verification/mmx_exec_assertions.sv
// assertion checker for the move, multiply and negate exec block
`timescale 1ns/1ps
`default_nettype none
`include "mmx_cfg.svh"
module mmx_exec_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // data memory
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_rdata
);
  logic [11:0] aw_reg, aw_next;
  logic [15:0] wd_reg, wd_next, run_reg, run_next;
  logic st_reg, st_next, bv_reg, ext_reg, ext_next, go;
  // running op is latched so an early next write cannot disturb the check
  always_comb begin
    aw_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_reg;
    wd_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[15:0] : wd_reg;
    st_next = (s_axi_wvalid && s_axi_wready) ? (&s_axi_wstrb[1:0]) : st_reg;
    go = s_axi_bvalid && !bv_reg && aw_reg == `MMX_OFF_INSTR && st_reg && s_axi_bresp == `MMX_RESP_OKAY;
    run_next = go ? wd_reg : run_reg;
    ext_next = ext_reg;
    if (s_axi_bvalid && !bv_reg && aw_reg == `MMX_OFF_CTRL && s_axi_bresp == `MMX_RESP_OKAY) begin
      ext_next = wd_reg[0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 12'h000;
      wd_reg <= 16'h0000;
      st_reg <= 1'b0;
      bv_reg <= 1'b0;
      run_reg <= 16'h0000;
      ext_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      st_reg <= st_next;
      bv_reg <= s_axi_bvalid;
      run_reg <= run_next;
      ext_reg <= ext_next;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_write_phase;
    ##4 mem_we;
  endsequence
  sequence s_no_write;
    ##1 !mem_we [*6];
  endsequence
  a_we_one_cycle: assert property (mem_we |=> !mem_we)
    else $error("memory write strobe longer than one cycle");
  a_store_writes: assert property (go && wd_reg[15:9] == `MMX_OP_STORE_FILE |-> s_write_phase)
    else $error("store did not write memory in its fourth phase");
  a_negate_writes: assert property (go && wd_reg[15:9] == `MMX_OP_NEG_FILE |-> s_write_phase)
    else $error("negate did not write memory in its fourth phase");
  a_mul_keeps_file: assert property (go && wd_reg[15:9] == `MMX_OP_MUL_FILE |-> s_no_write)
    else $error("multiply by file wrote memory");
  a_access_bank_addr: assert property (mem_we && !run_reg[8] && !(ext_reg && run_reg[7:0] <= 8'h5F)
    |-> mem_addr == ((run_reg[7:0] < 8'h60) ? {4'h0, run_reg[7:0]} : {4'hF, run_reg[7:0]}))
    else $error("access bank address wrong");
  a_bank_file_addr: assert property (mem_we && run_reg[8] |-> mem_addr[7:0] == run_reg[7:0])
    else $error("file address low byte wrong");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > 10'h007
    |=> s_axi_rvalid && s_axi_rresp == `MMX_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : mmx_exec_assertions
bind mmx_exec mmx_exec_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
`default_nettype wire

// file: verification/mmx_exec_test.sv
// self-checking bench for the exec block
`timescale 1ns/1ps
`default_nettype none
`include "mmx_cfg.svh"
module mmx_exec_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_we;
  logic [11:0] s_axi_awaddr, s_axi_araddr, mem_addr, idx;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
  logic [3:0] s_axi_wstrb, bank;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] mem_wdata, acc;
  wire logic [7:0] mem_rdata;
  logic [7:0] dmem [0:4095];
  logic [7:0] xmem [0:4095];
  logic [15:0] prod;
  logic [4:0] flg;
  logic ext;
  int bad_count, samples_checked;
  mmx_exec u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));
  // combinational read, as the memory port expects
  assign mem_rdata = dmem[mem_addr];
  always @(posedge aclk) begin
    if (mem_we) begin
      dmem[mem_addr] <= mem_wdata;
    end
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (a) begin
      return {bank, f};
    end
    if (ext && f <= 8'h5F) begin
      return idx + {4'h0, f};
    end
    return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
  endfunction : ea
  task finish_test();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // a wait that runs out is counted and ends the run
  task limit(input int n);
    if (n >= 400) begin
      check(32'h0, 32'h1);
      finish_test();
    end
  endtask : limit
  task automatic axi_write(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    int n;
    bit aw, w;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 0;
    w = 0;
    n = 0;
    while (!(aw && w) && n < 400) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid && n < 400) begin
      @(posedge aclk);
      n++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    limit(n);
  endtask : axi_write
  task automatic axi_read(input logic [11:0] ad, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 400);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 400);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(n);
  endtask : axi_read
  task automatic setcfg(input logic e, input logic [11:0] ix);
    logic [31:0] d;
    axi_write(`MMX_OFF_CTRL, {31'h0, e}, 4'hF, rs);
    axi_write(`MMX_OFF_INDEX, {20'h0, ix}, 4'h3, rs);
    ext = e;
    idx = ix;
    axi_read(`MMX_OFF_INDEX, d, rs);
    check(d, {20'h0, idx});
  endtask : setcfg
  // the bench model advances only after the hardware had its four phases
  task automatic exec(input logic [15:0] op);
    logic [11:0] ad;
    logic [7:0] m;
    logic [7:0] r;
    logic [31:0] d;
    ad = ea(op[8], op[7:0]);
    m = xmem[ad];
    axi_write(`MMX_OFF_INSTR, {16'h0, op}, 4'hF, rs);
    // busy while the four phases run, idle again one instruction cycle later
    axi_read(`MMX_OFF_STATE, d, rs);
    check(d, 32'h1);
    axi_read(`MMX_OFF_STATE, d, rs);
    check(d, 32'h0);
    if (op[15:8] == `MMX_OP_MOVE_LIT) begin
      acc = op[7:0];
    end else if (op[15:8] == `MMX_OP_MUL_LIT) begin
      prod = {8'h00, acc} * {8'h00, op[7:0]};
    end else if (op[15:8] == `MMX_OP_BANK_LIT) begin
      bank = op[3:0];
    end else if (op[15:9] == `MMX_OP_MUL_FILE) begin
      prod = {8'h00, acc} * {8'h00, m};
    end else if (op[15:9] == `MMX_OP_NEG_FILE) begin
      r = ~m + 8'h01;
      xmem[ad] = r;
      flg = {r[7], m == 8'h80, r == 8'h00, m[3:0] == 4'h0, m == 8'h00};
    end else if (op[15:9] == `MMX_OP_STORE_FILE) begin
      xmem[ad] = acc;
    end
    axi_read(`MMX_OFF_ACC, d, rs);
    check(d, {24'h0, acc});
    axi_read(`MMX_OFF_PROD, d, rs);
    check(d, {16'h0, prod});
    axi_read(`MMX_OFF_STATUS, d, rs);
    check(d, {27'h0, flg});
    axi_read(`MMX_OFF_BANK, d, rs);
    check(d, {28'h0, bank});
    check({24'h0, dmem[ad]}, {24'h0, xmem[ad]});
  endtask : exec
  initial begin
    logic [11:0] offs [8] = '{`MMX_OFF_CTRL, `MMX_OFF_INSTR, `MMX_OFF_ACC, `MMX_OFF_BANK, `MMX_OFF_PROD,
      `MMX_OFF_STATUS, `MMX_OFF_INDEX, `MMX_OFF_STATE};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    aresetn = 1'b0;
    seed = 32'h00000061;
    {acc, bank, prod, flg, ext, idx} = 46'h0;
    for (int i = 0; i < 4096; i++) begin
      v = rnd();
      dmem[i] = v[7:0];
      xmem[i] = v[7:0];
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) begin
      axi_read(offs[i], v, rs);
      check(v, 32'h0);
    end
    // unmapped and read-only places refuse and change nothing
    axi_read(12'h020, v, rs);
    check({30'h0, rs}, {30'h0, `MMX_RESP_SLVERR});
    axi_write(`MMX_OFF_PROD, 32'hFFFF, 4'hF, rs);
    check({30'h0, rs}, {30'h0, `MMX_RESP_SLVERR});
    // an instruction word written through one lane only starts nothing
    axi_write(`MMX_OFF_INSTR, 32'h00000E5A, 4'h1, rs);
    check({30'h0, rs}, {30'h0, `MMX_RESP_OKAY});
    axi_read(`MMX_OFF_ACC, v, rs);
    check(v, 32'h0);
    exec({`MMX_OP_MOVE_LIT, 8'hFF});
    exec({`MMX_OP_MUL_LIT, 8'hFF});
    exec({`MMX_OP_BANK_LIT, 8'hFA});
    exec({`MMX_OP_MOVE_LIT, 8'h80});
    exec({`MMX_OP_STORE_FILE, 1'b1, 8'h10});
    exec({`MMX_OP_NEG_FILE, 1'b1, 8'h10});
    exec({`MMX_OP_MOVE_LIT, 8'h00});
    exec({`MMX_OP_STORE_FILE, 1'b0, 8'hFF});
    exec({`MMX_OP_NEG_FILE, 1'b0, 8'hFF});
    setcfg(1'b1, 12'hFF0);
    exec({`MMX_OP_STORE_FILE, 1'b0, 8'h5F});
    exec({`MMX_OP_MUL_FILE, 1'b0, 8'h60});
    for (int i = 0; i < 90; i++) begin
      v = rnd();
      case (v[31:29])
        3'h0: exec({`MMX_OP_MOVE_LIT, v[7:0]});
        3'h1: exec({`MMX_OP_MUL_LIT, v[7:0]});
        3'h2: exec({`MMX_OP_BANK_LIT, v[7:0]});
        3'h3: exec({`MMX_OP_MUL_FILE, v[8], v[7:0]});
        3'h4: exec({`MMX_OP_NEG_FILE, v[8], v[7:0]});
        3'h5: exec({`MMX_OP_STORE_FILE, v[8], v[7:0]});
        default: setcfg(v[9], v[27:16]);
      endcase
    end
    finish_test();
  end
endmodule : mmx_exec_test
`default_nettype wire
